// ===== irt_target.sv
// Target end of the sensor serial port: framing, addressing, pointer.
// Assumes register map and EEPROM answer by req/ack on the user side.
module irt_target #(
   parameter int RELOAD_CYC = irt_pkg::RELOAD_CYC
) (
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_N_I,
   irt_bus_if.bus_target_side bus,
   input  wire logic       HI_SEL_I,
   input  wire logic       LO_SEL_I,
   output logic [5:0]      REG_ADDR_O,
   output logic            REG_RD_REQ_O,
   input  wire logic [7:0] REG_RD_DATA_I,
   input  wire logic       REG_RD_ACK_I,
   output logic            REG_WR_REQ_O,
   output logic [7:0]      REG_WR_DATA_O,
   input  wire logic       REG_WR_ALLOW_I,
   input  wire logic       REG_WR_ACK_I,
   output logic [5:0]      EE_ADDR_O,
   output logic            EE_RD_REQ_O,
   input  wire logic [7:0] EE_RD_DATA_I,
   input  wire logic       EE_RD_ACK_I,
   output logic            EE_READ_EN_O,
   output logic            BUS_BUSY_O,
   output logic            ADDR_VALID_O,
   output logic [6:0]      TARGET_ADDR_O
);
   logic [3:0] sync1_q, sync2_q;
   logic [1:0] prev_q;
   logic       scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
   irt_pkg::irt_tgt_state_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, ecr_q, ecr_d;
   logic [1:0] idx_q, idx_d;
   logic       rw_q, rw_d, gc_q, gc_d;
   logic [5:0] ptr_q, ptr_d;
   logic       scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic       rreq_q, rreq_d, wreq_q, wreq_d, ld_go, ee_want, ee_take;
   logic       ld_busy_q, ld_busy_d, loaded_q, loaded_d;
   logic [16:0] ld_cnt_q, ld_cnt_d;
   logic [7:0] sa_q, sa_d;
   logic [6:0] own_q, own_d;
   logic       ee_req_q, ee_req_d;
   logic [5:0] ee_addr_q, ee_addr_d;
   logic [15:0] idle_q, idle_d;
   logic       busy_q, busy_d;

   // Two-stage synchronisers for bus lines and select pins
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_q <= 4'hf;
         sync2_q <= 4'hf;
         prev_q  <= 2'h3;
      end else begin
         sync1_q <= {bus.scl, bus.sda, HI_SEL_I, LO_SEL_I};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q[3:2];
      end
   end

   // Line events from the synchronised levels
   assign scl      = sync2_q[3];
   assign sda      = sync2_q[2];
   assign scl_rise = scl && !prev_q[1];
   assign scl_fall = !scl && prev_q[1];
   assign start_ev = scl && prev_q[1] && prev_q[0] && !sda;
   assign stop_ev  = scl && prev_q[1] && !prev_q[0] && sda;
   assign ee_want  = (st_q == irt_pkg::TS_FETCH) &&
                     (ecr_q == irt_pkg::ECR_EE_READ);
   assign ee_take  = ee_want && ee_req_q && EE_RD_ACK_I && !ld_busy_q;

   // Byte framing, addressing, pointer and stretching
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      idx_d = idx_q;
      rw_d = rw_q;
      gc_d = gc_q;
      ptr_d = ptr_q;
      ecr_d = ecr_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      rreq_d = 1'b0;
      wreq_d = 1'b0;
      ld_go = 1'b0;
      case (st_q)
         irt_pkg::TS_IDLE: begin
            sda_oe_d = 1'b0;
         end
         irt_pkg::TS_RX: begin
            if (scl_rise) begin
               sh_d  = {sh_q[6:0], sda};
               bit_d = bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
               bit_d = 4'h0;
               if (idx_q == 2'd0) begin
                  rw_d = sh_q[0];
                  if (sh_q == irt_pkg::GCALL_BYTE) begin
                     gc_d     = 1'b1;
                     st_d     = irt_pkg::TS_ACK;
                     sda_oe_d = 1'b1;
                     ld_go    = !loaded_q;
                  end else if (loaded_q && sh_q[7:1] == own_q) begin
                     gc_d     = 1'b0;
                     st_d     = irt_pkg::TS_ACK;
                     sda_oe_d = 1'b1;
                  end else begin
                     st_d = irt_pkg::TS_IDLE;
                  end
               end else if (gc_q) begin
                  ld_go    = (sh_q == irt_pkg::RELOAD_CMD);
                  st_d     = irt_pkg::TS_ACK;
                  sda_oe_d = 1'b1;
               end else if (idx_q == 2'd1) begin
                  ptr_d    = sh_q[5:0];
                  st_d     = irt_pkg::TS_ACK;
                  sda_oe_d = 1'b1;
               end else begin
                  st_d     = irt_pkg::TS_STORE;
                  scl_oe_d = 1'b1;
               end
            end
         end
         irt_pkg::TS_STORE: begin
            if (!REG_WR_ALLOW_I || (wreq_q && REG_WR_ACK_I)) begin
               ptr_d    = irt_pkg::ptr_inc(ptr_q);
               ecr_d    = (ptr_q == irt_pkg::ECR_REG) ? sh_q : ecr_q;
               st_d     = irt_pkg::TS_ACK;
               sda_oe_d = 1'b1;
            end else begin
               wreq_d = 1'b1;
            end
         end
         irt_pkg::TS_ACK: begin
            scl_oe_d = 1'b0;
            if (scl_fall) begin
               sda_oe_d = 1'b0;
               idx_d    = (idx_q == 2'd2) ? idx_q : idx_q + 2'd1;
               if (rw_q && !gc_q) begin
                  st_d     = irt_pkg::TS_FETCH;
                  scl_oe_d = 1'b1;
               end else begin
                  st_d = irt_pkg::TS_RX;
               end
            end
         end
         irt_pkg::TS_FETCH: begin
            if (ee_take || (rreq_q && REG_RD_ACK_I)) begin
               sh_d     = ee_want ? EE_RD_DATA_I : REG_RD_DATA_I;
               sda_oe_d = ee_want ? !EE_RD_DATA_I[7] : !REG_RD_DATA_I[7];
               bit_d    = 4'h0;
               ptr_d    = irt_pkg::ptr_inc(ptr_q);
               st_d     = irt_pkg::TS_TX;
            end else begin
               rreq_d = !ee_want;
            end
         end
         irt_pkg::TS_TX: begin
            scl_oe_d = 1'b0;
            if (scl_fall) begin
               if (bit_q == 4'h7) begin
                  sda_oe_d = 1'b0;
                  st_d     = irt_pkg::TS_TXACK;
               end else begin
                  sh_d     = {sh_q[6:0], 1'b0};
                  sda_oe_d = !sh_q[6];
                  bit_d    = bit_q + 4'h1;
               end
            end
         end
         irt_pkg::TS_TXACK: begin
            if (scl_rise && sda) begin
               st_d = irt_pkg::TS_IDLE;
            end else if (scl_fall) begin
               st_d     = irt_pkg::TS_FETCH;
               scl_oe_d = 1'b1;
            end
         end
         default: begin
            st_d = irt_pkg::TS_IDLE;
         end
      endcase
      if (stop_ev) begin
         st_d     = irt_pkg::TS_IDLE;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
      end
      if (start_ev) begin
         st_d     = irt_pkg::TS_RX;
         bit_d    = 4'h0;
         idx_d    = 2'd0;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q     <= irt_pkg::TS_IDLE;
         bit_q    <= 4'h0;
         sh_q     <= 8'h00;
         idx_q    <= 2'd0;
         rw_q     <= 1'b0;
         gc_q     <= 1'b0;
         ptr_q    <= irt_pkg::PTR_RESET;
         ecr_q    <= irt_pkg::ECR_NORMAL;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rreq_q   <= 1'b0;
         wreq_q   <= 1'b0;
      end else begin
         st_q     <= st_d;
         bit_q    <= bit_d;
         sh_q     <= sh_d;
         idx_q    <= idx_d;
         rw_q     <= rw_d;
         gc_q     <= gc_d;
         ptr_q    <= ptr_d;
         ecr_q    <= ecr_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rreq_q   <= rreq_d;
         wreq_q   <= wreq_d;
      end
   end

   // Address loader and shared EEPROM port
   always_comb begin
      ld_busy_d = ld_busy_q;
      ld_cnt_d  = ld_cnt_q;
      loaded_d  = loaded_q;
      sa_d      = sa_q;
      own_d     = own_q;
      ee_req_d  = 1'b0;
      ee_addr_d = ee_addr_q;
      if (ld_busy_q) begin
         ee_addr_d = irt_pkg::SA_EE_LOC;
         if (ee_req_q && EE_RD_ACK_I) begin
            sa_d      = EE_RD_DATA_I;
            own_d     = irt_pkg::merge_addr(EE_RD_DATA_I, sync2_q[1:0]);
            loaded_d  = 1'b1;
            ld_busy_d = 1'b0;
         end else if (ld_cnt_q == 17'(RELOAD_CYC - 1)) begin
            own_d     = irt_pkg::merge_addr(sa_q, sync2_q[1:0]);
            loaded_d  = 1'b1;
            ld_busy_d = 1'b0;
         end else begin
            ee_req_d = 1'b1;
            ld_cnt_d = ld_cnt_q + 17'h1;
         end
      end else if (ld_go) begin
         ld_busy_d = 1'b1;
         ld_cnt_d  = 17'h0;
      end else if (ee_want) begin
         ee_addr_d = ptr_q;
         ee_req_d  = !(ee_req_q && EE_RD_ACK_I);
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ld_busy_q <= 1'b0;
         ld_cnt_q  <= 17'h0;
         loaded_q  <= 1'b0;
         sa_q      <= irt_pkg::SA_RESET;
         own_q     <= 7'h00;
         ee_req_q  <= 1'b0;
         ee_addr_q <= irt_pkg::PTR_RESET;
      end else begin
         ld_busy_q <= ld_busy_d;
         ld_cnt_q  <= ld_cnt_d;
         loaded_q  <= loaded_d;
         sa_q      <= sa_d;
         own_q     <= own_d;
         ee_req_q  <= ee_req_d;
         ee_addr_q <= ee_addr_d;
      end
   end

   // Bus busy from start until both lines stay high long enough
   always_comb begin
      idle_d = (scl && sda) ? idle_q + 16'h1 : 16'h0;
      busy_d = busy_q;
      if (idle_q == 16'(irt_pkg::BUS_IDLE_CYC - 1)) begin
         busy_d = 1'b0;
         idle_d = idle_q;
      end
      if (start_ev) begin
         busy_d = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         idle_q <= 16'h0;
         busy_q <= 1'b0;
      end else begin
         idle_q <= idle_d;
         busy_q <= busy_d;
      end
   end

   // Open-drain drive: output level always low
   assign bus.tgt_scl_out = 1'b0;
   assign bus.tgt_sda_out = 1'b0;
   assign bus.tgt_scl_oe  = scl_oe_q;
   assign bus.tgt_sda_oe  = sda_oe_q;
   assign REG_ADDR_O      = ptr_q;
   assign REG_RD_REQ_O    = rreq_q;
   assign REG_WR_REQ_O    = wreq_q;
   assign REG_WR_DATA_O   = sh_q;
   assign EE_ADDR_O       = ee_addr_q;
   assign EE_RD_REQ_O     = ee_req_q;
   assign EE_READ_EN_O    = (ecr_q == irt_pkg::ECR_EE_READ);
   assign BUS_BUSY_O      = busy_q;
   assign ADDR_VALID_O    = loaded_q;
   assign TARGET_ADDR_O   = own_q;

endmodule // irt_target

// ===== irt_pkg.sv
// Shared constants, state types and helpers for the sensor serial port.
// Assumes a single 250 MHz system clock on both ends of the link.
package irt_pkg;

   // Clock rate and derived timing
   localparam int CLK_MHZ       = 250;
   localparam int RELOAD_MAX_US = 300;
   localparam int RELOAD_CYC    = RELOAD_MAX_US * CLK_MHZ;
   localparam int BUS_IDLE_NS   = 1300;
   localparam int BUS_IDLE_CYC  = (BUS_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SCL_KHZ       = 400;
   localparam int SCL_QTR_CYC   =
      (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);

   // Protocol codes
   localparam logic [7:0] GCALL_BYTE  = 8'h00;
   localparam logic [7:0] RELOAD_CMD  = 8'h04;
   localparam logic [7:0] SA_RESET    = 8'h8c;
   localparam int         SA_CTRL_BIT = 7;

   // Register pointer and access control
   localparam logic [5:0] PTR_RESET   = 6'h00;
   localparam logic [5:0] ECR_REG     = 6'h1f;
   localparam logic [5:0] SA_EE_LOC   = 6'h3f;
   localparam logic [7:0] ECR_EE_READ = 8'h80;
   localparam logic [7:0] ECR_NORMAL  = 8'h00;

   typedef enum logic [2:0] {
      TS_IDLE   = 3'b000,
      TS_RX     = 3'b001,
      TS_ACK    = 3'b010,
      TS_STORE  = 3'b011,
      TS_FETCH  = 3'b100,
      TS_TX     = 3'b101,
      TS_TXACK  = 3'b110
   } irt_tgt_state_t;

   typedef enum logic [1:0] {
      HS_IDLE  = 2'b00,
      HS_START = 2'b01,
      HS_BIT   = 2'b10,
      HS_STOP  = 2'b11
   } irt_host_state_t;

   // Pointer step with wrap past the top location
   function automatic logic [5:0] ptr_inc(input logic [5:0] p);
      return p + 6'h01;
   endfunction

   // Target address from stored byte and the two select pins
   function automatic logic [6:0] merge_addr(input logic [7:0] sa,
                                             input logic [1:0] pins);
      return sa[SA_CTRL_BIT] ? {sa[6:2], pins} : sa[6:0];
   endfunction

endpackage

// ===== irt_bus_if.sv
// Two-wire open-drain bus joining the host end and the target end.
// Each party drives low only; the wire level is resolved here.
interface irt_bus_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic tgt_scl_out;
   logic tgt_scl_oe;
   logic tgt_sda_out;
   logic tgt_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND with pull-up: high unless someone drives low
   assign scl = !((host_scl_oe && !host_scl_out) ||
                  (tgt_scl_oe && !tgt_scl_out));
   assign sda = !((host_sda_oe && !host_sda_out) ||
                  (tgt_sda_oe && !tgt_sda_out));

   modport bus_host_side (
      output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
      input  scl, sda
   );
   modport bus_target_side (
      output tgt_scl_out, tgt_scl_oe, tgt_sda_out, tgt_sda_oe,
      input  scl, sda
   );
endinterface

// ===== irt_host.sv
// Host end of the sensor serial port: byte-level bus controller.
// Assumes one command per byte; user sequences build whole transfers.
module irt_host (
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_N_I,
   irt_bus_if.bus_host_side bus,
   input  wire logic       CMD_VALID_I,
   output logic            CMD_READY_O,
   input  wire logic       CMD_START_I,
   input  wire logic       CMD_STOP_I,
   input  wire logic       CMD_READ_I,
   input  wire logic       CMD_NACK_I,
   input  wire logic [7:0] CMD_DATA_I,
   output logic            RSP_VALID_O,
   output logic [7:0]      RSP_DATA_O,
   output logic            RSP_ACK_O
);
   logic [1:0] sync1_q, sync2_q;
   logic       scl_hi, sda_in, done, adv;
   irt_pkg::irt_host_state_t st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [7:0] tick_q, tick_d, sh_q, sh_d;
   logic [3:0] bit_q, bit_d;
   logic       start_q, start_d, stop_q, stop_d, rd_q, rd_d;
   logic       nack_q, nack_d, ack_q, ack_d;
   logic       scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic       rdy_q, rdy_d, rsp_q, rsp_d;

   // Line levels pass two flip-flops first
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_q <= 2'h3;
         sync2_q <= 2'h3;
      end else begin
         sync1_q <= {bus.scl, bus.sda};
         sync2_q <= sync1_q;
      end
   end

   assign scl_hi = sync2_q[1];
   assign sda_in = sync2_q[0];
   assign done   = (tick_q == 8'(irt_pkg::SCL_QTR_CYC - 1));

   // Quarter-period sequencer for start, bits and stop
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      start_d = start_q;
      stop_d = stop_q;
      rd_d = rd_q;
      nack_d = nack_q;
      ack_d = ack_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      rdy_d = 1'b0;
      rsp_d = 1'b0;
      adv = 1'b0;
      case (st_q)
         irt_pkg::HS_IDLE: begin
            rdy_d = !(CMD_VALID_I && rdy_q);
            if (CMD_VALID_I && rdy_q) begin
               sh_d   = CMD_DATA_I;
               stop_d = CMD_STOP_I;
               rd_d   = CMD_READ_I;
               nack_d = CMD_NACK_I;
               bit_d  = 4'h0;
               ph_d   = 2'd0;
               adv    = 1'b1;
               st_d   = CMD_START_I ? irt_pkg::HS_START : irt_pkg::HS_BIT;
               sda_oe_d = CMD_START_I ? 1'b0 : sda_oe_q;
            end
         end
         irt_pkg::HS_START: begin
            if (done && ph_q == 2'd0) begin
               scl_oe_d = 1'b0;
               ph_d = 2'd1;
               adv = 1'b1;
            end else if (done && ph_q == 2'd1 && scl_hi) begin
               sda_oe_d = 1'b1;
               ph_d = 2'd2;
               adv = 1'b1;
            end else if (done && ph_q == 2'd2) begin
               scl_oe_d = 1'b1;
               ph_d = 2'd0;
               st_d = irt_pkg::HS_BIT;
               adv = 1'b1;
            end
         end
         irt_pkg::HS_BIT: begin
            if (done && ph_q == 2'd0) begin
               if (bit_q == 4'h8) begin
                  sda_oe_d = rd_q && !nack_q;
               end else begin
                  sda_oe_d = !rd_q && !sh_q[7];
               end
               ph_d = 2'd1;
               adv = 1'b1;
            end else if (done && ph_q == 2'd1) begin
               scl_oe_d = 1'b0;
               ph_d = 2'd2;
               adv = 1'b1;
            end else if (done && ph_q == 2'd2 && scl_hi) begin
               if (bit_q == 4'h8) begin
                  ack_d = !sda_in;
               end else begin
                  sh_d = {sh_q[6:0], sda_in};
               end
               ph_d = 2'd3;
               adv = 1'b1;
            end else if (done && ph_q == 2'd3) begin
               scl_oe_d = 1'b1;
               ph_d = 2'd0;
               adv = 1'b1;
               if (bit_q == 4'h8) begin
                  rsp_d = 1'b1;
                  st_d  = stop_q ? irt_pkg::HS_STOP : irt_pkg::HS_IDLE;
                  rdy_d = !stop_q;
               end else begin
                  bit_d = bit_q + 4'h1;
               end
            end
         end
         irt_pkg::HS_STOP: begin
            if (done && ph_q == 2'd0) begin
               sda_oe_d = 1'b1;
               ph_d = 2'd1;
               adv = 1'b1;
            end else if (done && ph_q == 2'd1) begin
               scl_oe_d = 1'b0;
               ph_d = 2'd2;
               adv = 1'b1;
            end else if (done && ph_q == 2'd2 && scl_hi) begin
               sda_oe_d = 1'b0;
               st_d = irt_pkg::HS_IDLE;
               rdy_d = 1'b1;
               adv = 1'b1;
            end
         end
         default: begin
            st_d = irt_pkg::HS_IDLE;
         end
      endcase
      tick_d = adv ? 8'h00 : (done ? tick_q : tick_q + 8'h01);
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q     <= irt_pkg::HS_IDLE;
         ph_q     <= 2'd0;
         tick_q   <= 8'h00;
         bit_q    <= 4'h0;
         sh_q     <= 8'h00;
         start_q  <= 1'b0;
         stop_q   <= 1'b0;
         rd_q     <= 1'b0;
         nack_q   <= 1'b0;
         ack_q    <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rdy_q    <= 1'b0;
         rsp_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         ph_q     <= ph_d;
         tick_q   <= tick_d;
         bit_q    <= bit_d;
         sh_q     <= sh_d;
         start_q  <= start_d;
         stop_q   <= stop_d;
         rd_q     <= rd_d;
         nack_q   <= nack_d;
         ack_q    <= ack_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rdy_q    <= rdy_d;
         rsp_q    <= rsp_d;
      end
   end

   // Open-drain drive and user outputs
   assign bus.host_scl_out = 1'b0;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_scl_oe  = scl_oe_q;
   assign bus.host_sda_oe  = sda_oe_q;
   assign CMD_READY_O      = rdy_q;
   assign RSP_VALID_O      = rsp_q;
   assign RSP_DATA_O       = sh_q;
   assign RSP_ACK_O        = ack_q;

endmodule // irt_host

// ===== irt_bus_chk.sv
// Assertions on the two-wire link between the host and target ends.
// Assumes the signals of irt_bus_if and one 250 MHz clock.
module irt_bus_chk (
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic host_scl_out,
   input wire logic host_scl_oe,
   input wire logic host_sda_out,
   input wire logic host_sda_oe,
   input wire logic tgt_scl_out,
   input wire logic tgt_scl_oe,
   input wire logic tgt_sda_out,
   input wire logic tgt_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   localparam int STRETCH_MAX = 22500;
   logic [14:0] stretch_q;
   logic [14:0] stretch_d;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Length of the current target clock hold
   always_comb begin
      stretch_d = tgt_scl_oe ? stretch_q + 15'h0001 : 15'h0000;
   end
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         stretch_q <= 15'h0000;
      end else begin
         stretch_q <= stretch_d;
      end
   end
   // Start and stop as seen on the wires
   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence
   AST_OPEN_DRAIN: assert property (
      !(host_scl_out || host_sda_out || tgt_scl_out || tgt_sda_out))
      else $error("line driven high");
   AST_START_BY_HOST: assert property (
      start_s |-> host_sda_oe && !tgt_sda_oe) else $error("bad start");
   AST_TGT_SDA_STEADY: assert property (
      scl && $past(scl) |-> $stable(tgt_sda_oe))
      else $error("target moved data with clock high");
   AST_STOP_RELEASE: assert property (
      stop_s |=> (!tgt_scl_oe && !tgt_sda_oe) [*8])
      else $error("target drives after stop");
   AST_STRETCH_LOW: assert property (
      $rose(tgt_scl_oe) |-> !scl && $past(!scl))
      else $error("stretch cut a high phase");
   AST_STRETCH_BOUND: assert property (
      stretch_q < STRETCH_MAX) else $error("clock held too long");
   AST_SCL_HIGH_MIN: assert property (
      $rose(scl) |-> scl [*8]) else $error("clock high phase too short");
   AST_HOST_RESUMES: assert property (
      $fell(tgt_scl_oe) |-> ##[0:700] scl)
      else $error("host did not resume");
endmodule // irt_bus_chk

// ===== ir_sensor_i2c_target_port_test.sv
// Self-checking bench: host end talks to the target end over the link.
// Assumes user-side ports are answered one cycle after each request by responders here.
module ir_sensor_i2c_target_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] flg;
      logic [7:0] dat;
      logic       ack;
      logic [7:0] exp;
   } irt_row_t;
   logic       clk = 1'b0, rst_n = 1'b0, valid = 1'b0, rd_ack = 1'b0;
   logic       wr_ack = 1'b0, ee_ack = 1'b0, rdy, rv, rack, ra, rw, er;
   logic       c_s = 1'b0, c_p = 1'b0, c_r = 1'b0, c_n = 1'b0, busy, av;
   logic [7:0] c_d = 8'h00, rdat, wdat, mem [64];
   logic [5:0] radr;
   logic [6:0] tadr;
   irt_row_t   rows [10];
   int         errors = 0, check_count = 0, cycles = 0;
   irt_bus_if bus_if ();
   irt_host irt_host_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .bus(bus_if),
      .CMD_VALID_I(valid), .CMD_READY_O(rdy), .CMD_START_I(c_s),
      .CMD_STOP_I(c_p), .CMD_READ_I(c_r), .CMD_NACK_I(c_n), .CMD_DATA_I(c_d),
      .RSP_VALID_O(rv), .RSP_DATA_O(rdat), .RSP_ACK_O(rack));
   irt_target #(.RELOAD_CYC(200)) irt_target_inst (.SYS_CLK_I(clk),
      .RST_N_I(rst_n), .bus(bus_if), .HI_SEL_I(1'b1), .LO_SEL_I(1'b0),
      .REG_ADDR_O(radr), .REG_RD_REQ_O(ra), .REG_RD_DATA_I({2'b10, radr}),
      .REG_RD_ACK_I(rd_ack), .REG_WR_REQ_O(rw), .REG_WR_DATA_O(wdat),
      .REG_WR_ALLOW_I(radr != 6'h3f), .REG_WR_ACK_I(wr_ack),
      .EE_ADDR_O(), .EE_RD_REQ_O(er), .EE_RD_DATA_I(8'h8c),
      .EE_RD_ACK_I(ee_ack), .EE_READ_EN_O(), .BUS_BUSY_O(busy),
      .ADDR_VALID_O(av), .TARGET_ADDR_O(tadr));
   irt_bus_chk irt_bus_chk_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .host_scl_out(bus_if.host_scl_out), .host_scl_oe(bus_if.host_scl_oe),
      .host_sda_out(bus_if.host_sda_out), .host_sda_oe(bus_if.host_sda_oe),
      .tgt_scl_out(bus_if.tgt_scl_out), .tgt_scl_oe(bus_if.tgt_scl_oe),
      .tgt_sda_out(bus_if.tgt_sda_out), .tgt_sda_oe(bus_if.tgt_sda_oe),
      .scl(bus_if.scl), .sda(bus_if.sda));
   // Clock of 4 ns period
   always #2 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One byte command, then compare the byte and ninth bit seen on the wire
   task automatic send(input irt_row_t r);
      while (rdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      {c_s, c_p, c_r, c_n} <= r.flg;
      c_d <= r.dat;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      while (rv !== 1'b1) @(negedge clk);
      chk(rdat, r.exp);
      chk({7'h00, rack}, {7'h00, r.ack});
   endtask
   // User-side answers one cycle after a request; timeout guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      rd_ack <= ra && !rd_ack;
      wr_ack <= rw && !wr_ack;
      ee_ack <= er && !ee_ack;
      if (rw && !wr_ack) mem[radr] <= wdat;
      if (cycles == 95000) begin
         errors++;
         tally_and_finish();
      end
   end
   // Rows: unloaded address, call, reload, write wrap, read, refusal
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      rows = '{{4'b1100, 8'h1c, 1'b0, 8'h1c}, {4'b1000, 8'h00, 1'b1, 8'h00},
               {4'b0100, 8'h04, 1'b1, 8'h04}, {4'b1000, 8'h1c, 1'b1, 8'h1c},
               {4'b0000, 8'h3f, 1'b1, 8'h3f}, {4'b0000, 8'h5a, 1'b1, 8'h5a},
               {4'b0100, 8'h66, 1'b1, 8'h66}, {4'b1000, 8'h1d, 1'b1, 8'h1d},
               {4'b0010, 8'hff, 1'b1, 8'h81}, {4'b0111, 8'hff, 1'b0, 8'h82}};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         send(rows[i]);
         if (!rows[i].flg[2]) chk({7'h00, busy}, 8'h01);
      end
      // Stop phases plus the idle hold must pass before busy drops
      repeat (1200) @(posedge clk);
      chk({1'b0, tadr}, 8'h0e);
      chk({7'h00, av}, 8'h01);
      chk(mem[63], 8'h00);
      chk(mem[0], 8'h66);
      chk({7'h00, busy}, 8'h00);
      // Reset in mid-run drops the loaded address
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h00, av}, 8'h00);
      tally_and_finish();
   end
endmodule // ir_sensor_i2c_target_port_test
